// *** hw/wdwk_top.v ***
// Overview of operation
// RULE1: In sleep or idle, wake on reset pin, port fall, interrupt or overflow.
// RULE2: Reset-pin wake gives a full system reset.
// RULE3: Power-down flag clears at power-up and clear sequence, sets on halt.
// RULE4: Overflow in sleep/idle sets time-out flag, resets only PC and SP.
// RULE5: Each port pin has a wake enable; enabled falling edge wakes.
// RULE6: Port wake resumes at instruction after halt.
// RULE7: Disabled interrupt or full stack wake resumes after halt, service later.
// RULE8: Enabled interrupt with stack room wakes with normal interrupt response.
// RULE9: Interrupt already pending at halt is not a wake source.
// RULE10: Shared start-up counter: 15~16 fast cycles, else 1~2 cycles.
// RULE11: Sleep-to-normal wake waits for fast oscillator ready flag.
// RULE12: Watchdog on slow oscillator; 3-bit select, 256 doubling to 32768 clocks.
// RULE13: Control bit 7 keeps system clock running in idle when set.
// RULE14: Control bits 3~0 are plain read/write storage.
// RULE15: Overflow in normal run resets device and sets time-out flag.
// RULE16: Watchdog cleared by reset pin low, clear sequence, or halt.
// RULE17: The two clear commands clear only when alternated.
// RULE18: The single combined clear command has no effect.
// RULE19: Halt selects sleep, idle0 or idle1 from idle select and bit 7.
// RULE20: Entering sleep/idle clears watchdog, sets power-down, clears time-out.
// RULE21: Prescaler counter is at least 15 bits wide.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "wdwk_map.vh"

module wdwk_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        slow_osc_pin,
  input  wire        ext_reset_pin_n,
  input  wire [7:0]  port_pins,
  input  wire        irq_req,
  input  wire        irq_enabled,
  input  wire        stack_full,
  input  wire        high_osc_ready_flag,
  output reg         sys_reset,
  output reg         pc_sp_reset,
  output reg         irq_take,
  output reg         resume_pulse,
  output reg         cpu_run,
  output reg         sysclk_on,
  output reg         fast_osc_on
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0]  watchdog_control_q;
  reg [7:0]  port_wake_enable_q;
  reg        idle_select_q;
  reg        use_fast_q;
  reg        power_down_flag_q;
  reg        timeout_flag_q;
  reg        last_clr2_q;
  reg        clr_armed_q;
  reg [2:0]  mode_q;
  reg [4:0]  sst_q;
  reg        sst_wait_rdy_q;
  reg        irq_pend_at_halt_q;
  reg [1:0]  wake_kind_q;
  // RULE21: wide prescaler
  reg [15:0] wd_cnt_q;
  reg [2:0]  slow_sy_q;
  reg [2:0]  rst_sy_q;
  reg [7:0]  port_s1_q;
  reg [7:0]  port_s2_q;
  reg [7:0]  port_s3_q;
  reg [7:0]  port_st_q;
  reg        slow_st_q;
  reg        rst_st_q;
  reg [2:0]  rdy_sy_q;
  reg        rdy_st_q;
  reg [31:0] rd_word;
  reg        rd_bad;

  localparam K_PORT = 2'd0;
  localparam K_IRQ  = 2'd1;
  localparam K_WDT  = 2'd2;

  // Register select, shared by every strobe below
  function reg_hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      reg_hit = (addr == off);
    end
  endfunction

  wire       acc     = psel & penable & clk_en;
  wire       wr      = acc & pwrite;
  // Strobes fire only at the access edge that sees pready
  wire       cmd_wr  = wr & pready & reg_hit(paddr, `WDWK_CMD_OFF);
  wire       ctl_wr  = wr & pready & reg_hit(paddr, `WDWK_CTRL_OFF);
  wire       wen_wr  = wr & pready & reg_hit(paddr, `WDWK_WAKE_EN_OFF);
  wire       core_wr = wr & pready & reg_hit(paddr, `WDWK_CORE_OFF);
  // Halt outside run is ignored: the core is already stopped
  wire       halt_c  = cmd_wr & pwdata[`WDWK_CMD_HALT] & (mode_q == `WDWK_M_RUN);
  wire       clr1_c  = cmd_wr & pwdata[`WDWK_CMD_CLR1];
  wire       clr2_c  = cmd_wr & pwdata[`WDWK_CMD_CLR2];
  wire       asleep  = (mode_q == `WDWK_M_SLEEP) | (mode_q == `WDWK_M_IDLE0) |
                       (mode_q == `WDWK_M_IDLE1);

  // Filtered inputs: a change counts once stages two and three agree
  wire [7:0] port_new = (port_s2_q == port_s3_q) ? port_s3_q : port_st_q;
  wire       slow_new = (slow_sy_q[1] == slow_sy_q[2]) ? slow_sy_q[2] : slow_st_q;
  wire       rst_new  = (rst_sy_q[1] == rst_sy_q[2]) ? rst_sy_q[2] : rst_st_q;
  // The ready flag comes from the oscillator's own clock
  wire       rdy_new  = (rdy_sy_q[1] == rdy_sy_q[2]) ? rdy_sy_q[2] : rdy_st_q;
  wire       slow_tick = slow_new & ~slow_st_q;
  wire       pin_reset = ~rst_st_q;

  // RULE5: enabled falling edges
  wire       port_fall = |(port_st_q & ~port_new & port_wake_enable_q);
  // RULE9: pending-at-halt interrupt ignored
  wire       irq_wake  = irq_req & ~irq_pend_at_halt_q;

  // Both clear bits in one write count as neither
  // RULE17: alternate clears only; RULE18: combined clear ignored
  wire       sw_clear = (clr1_c & ~clr2_c & (~clr_armed_q | last_clr2_q)) |
                        (clr2_c & ~clr1_c & (~clr_armed_q | ~last_clr2_q));

  // RULE12: timeout length by select code
  function [15:0] wd_limit;
    input [2:0] sel;
    begin
      wd_limit = `WDWK_BASE_DIV << sel;
    end
  endfunction

  wire [15:0] limit = wd_limit(watchdog_control_q[`WDWK_TSEL_HI:`WDWK_TSEL_LO]);
  wire        wd_ovf = slow_tick & (wd_cnt_q == limit - 16'h0001);

  // Idle1 keeps its clock, so its start-up is short; counted in pclk cycles
  function [4:0] start_len;
    input fast;
    input keep_clk;
    begin
      start_len = (fast & ~keep_clk) ? `WDWK_SST_FAST : `WDWK_SST_SLOW;
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Filters start at the pins' idle levels, so no false edge follows reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sy_q <= 3'h0;
      rst_sy_q  <= 3'h7;
      port_s1_q <= 8'hff;
      port_s2_q <= 8'hff;
      port_s3_q <= 8'hff;
      port_st_q <= 8'hff;
      slow_st_q <= 1'b0;
      rst_st_q  <= 1'b1;
      rdy_sy_q  <= 3'h0;
      rdy_st_q  <= 1'b0;
    end else if (clk_en) begin
      slow_sy_q <= {slow_sy_q[1:0], slow_osc_pin};
      rdy_sy_q  <= {rdy_sy_q[1:0], high_osc_ready_flag};
      rdy_st_q  <= rdy_new;
      rst_sy_q  <= {rst_sy_q[1:0], ext_reset_pin_n};
      port_s1_q <= port_pins;
      port_s2_q <= port_s1_q;
      port_s3_q <= port_s2_q;
      port_st_q <= port_new;
      slow_st_q <= slow_new;
      rst_st_q  <= rst_new;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter and flags
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q          <= 16'h0000;
      power_down_flag_q <= 1'b0;
      timeout_flag_q    <= 1'b0;
      last_clr2_q       <= 1'b0;
      clr_armed_q       <= 1'b0;
    end else if (clk_en) begin
      // Overflow restarts the count, so a long sleep wakes periodically
      // RULE16: three clear sources
      if (pin_reset | sw_clear | halt_c | wd_ovf) begin
        wd_cnt_q <= 16'h0000;
      end else if (slow_tick) begin
        wd_cnt_q <= wd_cnt_q + 16'h0001;
      end
      if (sw_clear) begin
        clr_armed_q <= 1'b1;
        last_clr2_q <= clr2_c;
      end
      // RULE3: power-down flag
      // RULE20: halt sets flags
      if (halt_c) begin
        power_down_flag_q <= 1'b1;
      end else if (sw_clear | pin_reset) begin
        power_down_flag_q <= 1'b0;
      end
      // Set beats clear, so an overflow in a clear's cycle is kept
      // RULE4: time-out flag; RULE15: also in run
      if (wd_ovf) begin
        timeout_flag_q <= 1'b1;
      end else if (halt_c | sw_clear | pin_reset) begin
        timeout_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q             <= `WDWK_M_RUN;
      sst_q              <= 5'h00;
      sst_wait_rdy_q     <= 1'b0;
      irq_pend_at_halt_q <= 1'b0;
      wake_kind_q        <= K_PORT;
      sys_reset          <= 1'b0;
      pc_sp_reset        <= 1'b0;
      irq_take           <= 1'b0;
      resume_pulse       <= 1'b0;
      cpu_run            <= 1'b1;
      sysclk_on          <= 1'b1;
      fast_osc_on        <= 1'b1;
    end else if (clk_en) begin
      // Result pulses last one cycle, but sys_reset stays high while the reset pin is low; the core must act on them at once
      sys_reset    <= 1'b0;
      pc_sp_reset  <= 1'b0;
      irq_take     <= 1'b0;
      resume_pulse <= 1'b0;
      if (!irq_req) begin
        irq_pend_at_halt_q <= 1'b0;
      end
      // Reset pin outranks every mode and every wake source
      if (pin_reset) begin
        // RULE2: full reset on pin
        sys_reset   <= 1'b1;
        mode_q      <= `WDWK_M_RUN;
        cpu_run     <= 1'b1;
        sysclk_on   <= 1'b1;
        fast_osc_on <= 1'b1;
      end else begin
        case (mode_q)
          `WDWK_M_RUN: begin
            // RULE15: overflow in run resets
            if (wd_ovf) begin
              sys_reset <= 1'b1;
            end else if (halt_c) begin
              irq_pend_at_halt_q <= irq_req;
              cpu_run <= 1'b0;
              // RULE19: mode select
              // RULE13: system clock in idle
              if (!idle_select_q) begin
                mode_q      <= `WDWK_M_SLEEP;
                sysclk_on   <= 1'b0;
                fast_osc_on <= 1'b0;
              end else if (!watchdog_control_q[`WDWK_SYSCLK_BIT]) begin
                mode_q      <= `WDWK_M_IDLE0;
                sysclk_on   <= 1'b0;
                fast_osc_on <= 1'b0;
              end else begin
                mode_q <= `WDWK_M_IDLE1;
              end
            end
          end
          `WDWK_M_SLEEP, `WDWK_M_IDLE0, `WDWK_M_IDLE1: begin
            // RULE1: wake sources
            if (asleep & (wd_ovf | port_fall | irq_wake)) begin
              wake_kind_q <= wd_ovf ? K_WDT : (port_fall ? K_PORT : K_IRQ);
              mode_q      <= `WDWK_M_START;
              fast_osc_on <= use_fast_q;
              sysclk_on   <= 1'b1;
              // RULE10: shared start-up count
              sst_q <= start_len(use_fast_q, mode_q == `WDWK_M_IDLE1);
              sst_wait_rdy_q <= use_fast_q & (mode_q == `WDWK_M_SLEEP);
            end
          end
          `WDWK_M_START: begin
            if (sst_q != 5'h00) begin
              sst_q <= sst_q - 5'h01;
            // RULE11: wait for fast ready
            end else if (!sst_wait_rdy_q | rdy_st_q) begin
              mode_q  <= `WDWK_M_RUN;
              cpu_run <= 1'b1;
              case (wake_kind_q)
                // RULE4: only PC and SP reset
                K_WDT: pc_sp_reset <= 1'b1;
                // RULE8: normal interrupt response
                // RULE7: otherwise resume, serviced later
                K_IRQ: begin
                  if (irq_enabled & ~stack_full) begin
                    irq_take <= 1'b1;
                  end else begin
                    resume_pulse <= 1'b1;
                  end
                end
                // RULE6: resume after halt
                default: resume_pulse <= 1'b1;
              endcase
            end
          end
          default: mode_q <= `WDWK_M_RUN;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Latched at setup, so read data stands through the access cycle
  wire [7:0] status_byte = {1'b0, mode_q, 2'b00, timeout_flag_q, power_down_flag_q};

  always @* begin
    rd_word = 32'h0000_0000;
    rd_bad  = 1'b0;
    case (paddr)
      `WDWK_CTRL_OFF:    rd_word = {24'h0, watchdog_control_q};
      `WDWK_CMD_OFF:     rd_word = 32'h0000_0000;
      `WDWK_STAT_OFF:    rd_word = {24'h0, status_byte};
      `WDWK_WAKE_EN_OFF: rd_word = {24'h0, port_wake_enable_q};
      `WDWK_CORE_OFF:    rd_word = {30'h0, use_fast_q, idle_select_q};
      default:           rd_bad  = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_control_q <= `WDWK_CTRL_RST;
      port_wake_enable_q <= 8'h00;
      idle_select_q      <= 1'b0;
      use_fast_q         <= 1'b1;
      prdata             <= 32'h0000_0000;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      // An unmapped offset is answered with an error and its write dropped
      pslverr <= psel & ~penable & rd_bad;
      if (psel & ~penable) begin
        prdata <= rd_word;
      end
      // RULE14: low bits plain storage
      if (ctl_wr) begin
        watchdog_control_q <= pwdata[7:0];
      end
      if (wen_wr) begin
        port_wake_enable_q <= pwdata[7:0];
      end
      if (core_wr) begin
        idle_select_q <= pwdata[`WDWK_CORE_IDLE_SEL];
        use_fast_q    <= pwdata[`WDWK_CORE_FAST];
      end
    end
  end

endmodule // wdwk_top

// *** hw/wdwk_map.vh ***
`ifndef WDWK_MAP_VH
`define WDWK_MAP_VH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define WDWK_CTRL_OFF      12'h000
`define WDWK_CMD_OFF       12'h004
`define WDWK_STAT_OFF      12'h008
`define WDWK_WAKE_EN_OFF   12'h00c
`define WDWK_CORE_OFF      12'h010
`define WDWK_CTRL_RST      8'h7a
`define WDWK_SYSCLK_BIT    7
`define WDWK_TSEL_HI       6
`define WDWK_TSEL_LO       4
// Command bits
`define WDWK_CMD_HALT      0
`define WDWK_CMD_CLR1      1
`define WDWK_CMD_CLR2      2
`define WDWK_CMD_CLRS      3
// Core-status bits
`define WDWK_CORE_IDLE_SEL 0
`define WDWK_CORE_FAST     1
// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define WDWK_BASE_DIV      16'h0100
`define WDWK_SST_FAST      5'h10
`define WDWK_SST_SLOW      5'h02
// ----------------------------------------------------------------
// Modes
// ----------------------------------------------------------------
`define WDWK_M_RUN         3'h0
`define WDWK_M_SLEEP       3'h1
`define WDWK_M_IDLE0       3'h2
`define WDWK_M_IDLE1       3'h3
`define WDWK_M_START       3'h4
`endif

// *** tb/wdwk_monitor.sv ***
`timescale 1ns/100ps
// ------------------------------------------
// Port checks on the watchdog/wake-up block
// ------------------------------------------
module wdwk_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_reset_pin_n,
  input wire logic        irq_enabled,
  input wire logic        stack_full,
  input wire logic        high_osc_ready_flag,
  input wire logic        sys_reset,
  input wire logic        pc_sp_reset,
  input wire logic        irq_take,
  input wire logic        resume_pulse,
  input wire logic        cpu_run,
  input wire logic        fast_osc_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_pin_low;
    !ext_reset_pin_n [*4];
  endsequence
  sequence s_wake;
    pc_sp_reset || irq_take || resume_pulse;
  endsequence
  AST_READY_NEXT: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready && clk_en |=> !pready)
    else $error("ready held too long");
  AST_UNMAPPED: assert property (psel && !penable && clk_en &&
    !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010}) |=> pslverr)
    else $error("unmapped access not refused");
  AST_PIN_RESET: assert property (s_pin_low |-> ##[0:4] sys_reset)
    else $error("reset pin gave no reset");
  AST_ONE_WAKE: assert property ($onehot0({pc_sp_reset, irq_take, resume_pulse}))
    else $error("several wake results");
  AST_IRQ_GATE: assert property (irq_take |-> $past(irq_enabled) && !$past(stack_full))
    else $error("interrupt taken while blocked");
  AST_FAST_READY: assert property (s_wake ##0 fast_osc_on |-> high_osc_ready_flag)
    else $error("resumed before oscillator ready");
  AST_WAKE_RUNS: assert property (s_wake |-> ##[0:1] cpu_run)
    else $error("wake without run");
endmodule // wdwk_monitor

bind wdwk_top wdwk_monitor u_mon (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .ext_reset_pin_n(ext_reset_pin_n), .irq_enabled(irq_enabled), .stack_full(stack_full),
  .high_osc_ready_flag(high_osc_ready_flag), .sys_reset(sys_reset),
  .pc_sp_reset(pc_sp_reset), .irq_take(irq_take), .resume_pulse(resume_pulse),
  .cpu_run(cpu_run), .fast_osc_on(fast_osc_on));

// *** tb/wdwk_core_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------
// Oscillators seen by the block
// ------------------------------------------
module wdwk_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fast_osc_on,
  output logic      slow_osc_pin,
  output logic      high_osc_ready_flag
);
  logic [1:0] div_q;
  logic [2:0] rdy_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  assign slow_osc_pin = div_q[1];
  always @(posedge pclk) begin
    if (!fast_osc_on) rdy_q <= 3'h0;
    else rdy_q <= {rdy_q[1:0], 1'b1};
  end
  assign high_osc_ready_flag = rdy_q[2];
endmodule // wdwk_core_model

// *** tb/test_watchdog_wakeup_ctrl.sv ***
`timescale 1ns/100ps
`include "wdwk_map.vh"
module test_watchdog_wakeup_ctrl;
  localparam logic [11:0] A_CTL = `WDWK_CTRL_OFF, A_CMD = `WDWK_CMD_OFF;
  localparam logic [11:0] A_ST = `WDWK_STAT_OFF, A_WE = `WDWK_WAKE_EN_OFF, A_CO = `WDWK_CORE_OFF;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        ext_n = 1, irq_req = 0, irq_en = 0, stk = 0, ce = 1, err_v;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd_v;
  logic [7:0]  port_pins = 8'hff;
  wire  [31:0] prdata;
  wire         pready, pslverr, slow, rdy, sys_rst, pcsp, itake, resume, run, fast_on, sclk;
  int          miscompares = 0, check_count = 0;
  always #20 pclk = ~pclk;
  wdwk_top dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_osc_pin(slow), .ext_reset_pin_n(ext_n),
    .port_pins(port_pins), .irq_req(irq_req), .irq_enabled(irq_en), .stack_full(stk),
    .high_osc_ready_flag(rdy), .sys_reset(sys_rst), .pc_sp_reset(pcsp), .irq_take(itake),
    .resume_pulse(resume), .cpu_run(run), .sysclk_on(sclk), .fast_osc_on(fast_on));
  wdwk_core_model u_core (.pclk(pclk), .presetn(presetn), .fast_osc_on(fast_on),
    .slow_osc_pin(slow), .high_osc_ready_flag(rdy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle edge first, so a release is never overwritten in the same step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) begin
      @(posedge pclk);
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  task automatic waitp(input logic [3:0] m);
    int n;
    n = 0;
    @(posedge pclk);
    while (({sys_rst, pcsp, itake, resume} & m) == 4'h0 && n < 4000) begin
      n++;
      @(posedge pclk);
    end
    chk({sys_rst, pcsp, itake, resume}, m);
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, 32'h7a);
    rd(A_ST, 32'h0);
    rd(12'h014, 32'h0);
    chk(err_v, 1'b1);
    apb(1'b1, A_CTL, 32'h85);
    rd(A_CTL, 32'h85);
    waitp(4'h8);
    rd(A_ST, 32'h2);
    apb(1'b1, A_WE, 32'h1);
    apb(1'b1, A_CO, 32'h2);
    apb(1'b1, A_CMD, 32'h1);
    rd(A_ST, 32'h11);
    chk(sclk, 1'b0);
    chk(run, 1'b0);
    ce <= 1'b0;
    port_pins <= 8'hfe;
    repeat (40) @(posedge pclk);
    chk(run, 1'b0);
    ce <= 1'b1;
    waitp(4'h1);
    port_pins <= 8'hff;
    rd(A_ST, 32'h1);
    apb(1'b1, A_CMD, 32'h8);
    rd(A_ST, 32'h1);
    apb(1'b1, A_CMD, 32'h2);
    rd(A_ST, 32'h0);
    apb(1'b1, A_CMD, 32'h1);
    waitp(4'h4);
    rd(A_ST, 32'h3);
    apb(1'b1, A_CMD, 32'h2);
    rd(A_ST, 32'h3);
    apb(1'b1, A_CO, 32'h3);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, A_CMD, 32'h1);
      rd(A_ST, 32'h31);
      chk(sclk, 1'b1);
      irq_en <= (i != 0);
      stk <= (i == 2);
      irq_req <= 1'b1;
      waitp(i == 1 ? 4'h2 : 4'h1);
      irq_req <= 1'b0;
    end
    @(posedge pclk);
    irq_req <= 1'b1;
    apb(1'b1, A_CMD, 32'h1);
    repeat (40) @(posedge pclk);
    rd(A_ST, 32'h31);
    irq_req <= 1'b0;
    repeat (2) @(posedge pclk);
    irq_req <= 1'b1;
    waitp(4'h1);
    irq_req <= 1'b0;
    apb(1'b1, A_CO, 32'h0);
    apb(1'b1, A_CMD, 32'h1);
    ext_n <= 1'b0;
    waitp(4'h8);
    ext_n <= 1'b1;
    wrap_up;
  end
endmodule // test_watchdog_wakeup_ctrl
